// ---- rtl/pcic_ctrl.sv ----
// pcic_ctrl.sv: decoder-side sequencer for prime and inject
// assumes: ref_clk 100 MHz; start requests from user logic
`timescale 1ns/1ns
`default_nettype none
`include "pcic_defines.svh"
module pcic_ctrl
    import pcic_pkg::*;
#(
    parameter int BASE_PERIOD = `PCIC_BASE_PERIOD_CYC
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rstn,
    pcic_if.ctrl                          bus,
    input  wire logic                     start,
    input  wire logic                     double_pulse,
    input  wire logic [15:0]              settle_cycles,
    input  wire logic [15:0]              edge_cycles,
    input  wire logic                     mode,
    input  wire logic [`PCIC_DELAY_W-1:0] delay,
    output logic                          busy
);
    pcic_ctl_s r;
    pcic_ctl_s next_r;

    // one command sequence: prime, settle, strobe, aux (strobe falls only if double pulse), done
    always_comb begin
        next_r = r;
        next_r.base_count = r.base_count + 16'h0001;
        if (r.base_count >= 16'(BASE_PERIOD - 1)) begin
            next_r.base_count = '0;
        end
        next_r.baseline = (r.base_count < 16'(`PCIC_BASE_LEN_CYC));
        case (r.state)
            PCIC_IDLE: begin
                if (start) begin
                    next_r.state        = PCIC_PRIME;
                    next_r.busy         = 1'b1;
                    next_r.double_pulse = double_pulse;
                end
            end
            PCIC_PRIME: begin
                next_r.edge_lvl = 1'b0;
                next_r.aux_lvl  = 1'b0;
                next_r.count    = settle_cycles;
                next_r.state    = PCIC_SETTLE;
            end
            PCIC_SETTLE: begin
                next_r.count = r.count - 16'h0001;
                if (r.count == '0) begin
                    next_r.edge_lvl = 1'b1;
                    next_r.count    = edge_cycles;
                    next_r.state    = PCIC_EDGE;
                end
            end
            PCIC_EDGE: begin
                next_r.count = r.count - 16'h0001;
                if (r.count == '0) begin
                    next_r.aux_lvl = 1'b1;
                    next_r.state   = PCIC_AUX;
                end
            end
            PCIC_AUX: begin
                if (r.double_pulse) begin
                    next_r.edge_lvl = 1'b0;
                end
                next_r.state = PCIC_DONE;
            end
            PCIC_DONE: begin
                next_r.busy  = 1'b0;
                next_r.state = PCIC_IDLE;
            end
            default: begin
                next_r.state = PCIC_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign bus.inject_strobe = r.edge_lvl;
    assign bus.inject_aux    = r.aux_lvl;
    assign bus.inject_mode   = mode;
    assign bus.fine_delay    = delay;
    assign bus.baseline_acq  = r.baseline;
    assign busy              = r.busy;
endmodule
`default_nettype wire

// ---- rtl/pcic_defines.svh ----
// pcic_defines.svh: constants of the calibration injection control
// assumes: included by bare name from pcic package and modules
`ifndef PCIC_DEFINES_SVH
`define PCIC_DEFINES_SVH
`define PCIC_MODE_UNIFORM     1'b0
`define PCIC_MODE_ALTERNATING 1'b1
`define PCIC_DELAY_W          4
`define PCIC_DELAY_RESET      4'h0
`define PCIC_SKEW_NS          2
`define PCIC_CLK_NS           10
`define PCIC_BASE_PERIOD_US   100
`define PCIC_BASE_LEN_NS      100
`define PCIC_BASE_LEN_CYC \
    ((`PCIC_BASE_LEN_NS + `PCIC_CLK_NS - 1) / `PCIC_CLK_NS)
`define PCIC_BASE_PERIOD_CYC \
    ((`PCIC_BASE_PERIOD_US * 1000) / `PCIC_CLK_NS)
`endif

// ---- rtl/pcic_delay_line.sv ----
// pcic_delay_line.sv: chip-wide phase shift of the strobe
// assumes: one instance per pixel, all sharing fine_delay; delay is static
`timescale 1ns/1ns
`default_nettype none
`include "pcic_defines.svh"
module pcic_delay_line
    import pcic_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rstn,
    input  wire logic                     din,
    input  wire logic [`PCIC_DELAY_W-1:0] sel,
    output logic                          dout
);
    logic [DEPTH-1:0] taps;
    logic [DEPTH-1:0] next_taps;

    // shift register of strobe samples
    always_comb begin
        next_taps = {taps[DEPTH-2:0], din};
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            taps <= '0;
        end else begin
            taps <= next_taps;
        end
    end

    // tap zero is the raw strobe, no added phase
    assign dout = (sel == '0) ? din : taps[sel - 1'b1];
endmodule
`default_nettype wire

// ---- rtl/pcic_if.sv ----
// pcic_if.sv: array-wide calibration signals, decoder to pixel
// assumes: one clock, ref_clk, shared by both ends
`timescale 1ns/1ns
`default_nettype none
`include "pcic_defines.svh"
interface pcic_if;
    logic                      inject_strobe;
    logic                      inject_aux;
    logic                      inject_mode;
    logic [`PCIC_DELAY_W-1:0]  fine_delay;
    logic                      baseline_acq;
    modport ctrl (
        output inject_strobe,
        output inject_aux,
        output inject_mode,
        output fine_delay,
        output baseline_acq
    );
    modport pixel (
        input inject_strobe,
        input inject_aux,
        input inject_mode,
        input fine_delay,
        input baseline_acq
    );
endinterface
`default_nettype wire

// ---- rtl/pcic_pixel.sv ----
// pcic_pixel.sv: per-pixel derivation of the two inject switches
// assumes: strobe and aux are array-wide, from the command decoder
`timescale 1ns/1ns
`default_nettype none
`include "pcic_defines.svh"
// Operation
// - inject only when enabled, on switch rise
// - controller primes by lowering a switch first
// - each pixel holds own calibration enable
// - one global fine delay shifts the strobe
// - uniform: first=or, second=not strobe and aux
// - strobe rise fires first, fall fires second
// - aux starts low, rises after strobe
// - alternating: odd pixels swap both switches
// - parity is row plus column
// - switch assignment ignores the enable
// - mode bit: 0 uniform, 1 alternating
// - strobe reaches all pixels within 2 ns
// - controller fires first before second
// - two pulses after one priming allowed
// - single pulse: hold second, toggle first
// - controller leaves settling after priming
// - strobe edge time and width user set
// - switches derived locally from two signals
// - one command primes and injects
// - baseline every 100 us, lasting 100 ns
module pcic_pixel
    import pcic_pkg::*;
#(
    parameter int ROW_W = 9,
    parameter int COL_W = 9,
    parameter int DEPTH = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    pcic_if.pixel                  bus,
    input  wire logic [ROW_W-1:0]  row,
    input  wire logic [COL_W-1:0]  col,
    input  wire logic              cfg_write,
    input  wire logic              cfg_enable,
    output logic                   cal_enable,
    output logic                   first_inject_switch,
    output logic                   second_inject_switch,
    output logic                   inject_upper,
    output logic                   inject_middle,
    output logic                   baseline_hold
);
    typedef struct packed {
        logic enable;
        logic prev_first;
        logic prev_second;
    } pcic_pix_s;

    pcic_pix_s r;
    pcic_pix_s next_r;
    logic      strobe_d;
    logic      or_term;
    logic      and_term;
    logic      odd;

    // global phase shift, one setting for all pixels
    pcic_delay_line #(.DEPTH(DEPTH)) pcic_delay_line_inst (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .din     (bus.inject_strobe),
        .sel     (bus.fine_delay),
        .dout    (strobe_d)
    );

    // local switch derivation, no flops on the path
    always_comb begin
        or_term  = strobe_d | bus.inject_aux;
        and_term = ~strobe_d & bus.inject_aux;
        odd      = row[0] ^ col[0];
        if (bus.inject_mode == `PCIC_MODE_ALTERNATING && odd) begin
            first_inject_switch  = and_term;
            second_inject_switch = or_term;
        end else begin
            first_inject_switch  = or_term;
            second_inject_switch = and_term;
        end
    end

    // enable bit and edge history
    always_comb begin
        next_r             = r;
        if (cfg_write) begin
            next_r.enable  = cfg_enable;
        end
        next_r.prev_first  = first_inject_switch;
        next_r.prev_second = second_inject_switch;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // injection pulses on rising switches, enabled pixels only
    assign inject_upper  = r.enable & first_inject_switch
                           & ~r.prev_first;
    assign inject_middle = r.enable & second_inject_switch
                           & ~r.prev_second;
    assign cal_enable    = r.enable;
    assign baseline_hold = bus.baseline_acq;
endmodule
`default_nettype wire

// ---- rtl/pcic_pkg.sv ----
// pcic_pkg.sv: types of the calibration injection control
// assumes: pcic_defines.svh on the include path
`include "pcic_defines.svh"
package pcic_pkg;
    typedef enum logic [2:0] {
        PCIC_IDLE   = 3'b000,
        PCIC_PRIME  = 3'b001,
        PCIC_SETTLE = 3'b010,
        PCIC_EDGE   = 3'b011,
        PCIC_AUX    = 3'b100,
        PCIC_FALL   = 3'b101,
        PCIC_DONE   = 3'b110
    } pcic_state_e;
    typedef struct packed {
        pcic_state_e  state;
        logic [15:0]  count;
        logic [15:0]  base_count;
        logic         edge_lvl;
        logic         aux_lvl;
        logic         baseline;
        logic         busy;
        logic         double_pulse;
    } pcic_ctl_s;
endpackage

// ---- sim/pcic_props.sv ----
// pcic_props.sv: checks on the array-wide calibration signals
// assumes: instantiated beside pcic_if in the bench
`timescale 1ns/1ns
`default_nettype none
module pcic_props
#(
    parameter int BASE_PERIOD = 50
) (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       inject_strobe,
    input  wire logic       inject_aux,
    input  wire logic       inject_mode,
    input  wire logic [3:0] fine_delay,
    input  wire logic       baseline_acq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic [15:0] hi_n;
    logic [15:0] gap_n;
    // baseline length and spacing counters
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hi_n <= 16'h0;
            gap_n <= 16'h0;
        end else begin
            hi_n <= baseline_acq ? hi_n + 16'h1 : 16'h0;
            gap_n <= (baseline_acq && hi_n == 16'h0) ? 16'h1 : gap_n + 16'h1;
        end
    end
    a_aux_after_edge: assert property (
        $rose(inject_aux) |-> inject_strobe)
        else $error("aux rose before strobe");
    a_edge_primed: assert property (
        $rose(inject_strobe) |-> !$past(inject_aux))
        else $error("strobe rose without priming");
    a_second_order: assert property (
        $fell(inject_strobe) && inject_aux |-> $past(inject_aux))
        else $error("second switch fired before first");
    a_aux_stands: assert property (
        $rose(inject_aux) |-> inject_aux[*3])
        else $error("aux dropped too soon");
    a_delay_steady: assert property (
        $rose(inject_strobe) |-> $stable(fine_delay))
        else $error("fine delay moved at strobe");
    a_mode_steady: assert property (
        $rose(inject_aux) |-> $stable(inject_mode))
        else $error("mode moved during injection");
    a_base_length: assert property (
        $fell(baseline_acq) |-> hi_n == 16'ha)
        else $error("baseline length wrong");
    a_base_period: assert property (
        gap_n <= BASE_PERIOD)
        else $error("baseline spacing too long");
endmodule
`default_nettype wire

// ---- sim/pixel_cal_injection_control_bench.sv ----
// bench: one sequencer driving an even and an odd pixel
// assumes: rtl package, interface and modules compiled first
`timescale 1ns/1ns
`default_nettype none
module pixel_cal_injection_control_bench;
    import pcic_pkg::*;
    localparam int BASE_PERIOD = 50;  // shortened baseline period for sim
    localparam int BASE_LEN    = 10;  // 100 ns at 10 ns per cycle
    int          cyc = 0;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        start = 1'b0;
    logic        dbl = 1'b0;
    logic        mode = 1'b0;
    logic [3:0]  delay = 4'h0;
    logic [15:0] settle = 16'h1;
    logic [15:0] edge_len = 16'h1;
    logic [15:0] hist = 16'h0;
    logic [1:0]  wr = 2'h0;
    logic [1:0]  en_in = 2'h0;
    logic [1:0]  den = 2'h0;
    logic [1:0]  pf = 2'h0;
    logic [1:0]  ps = 2'h0;
    logic [1:0]  en, fs, ss, up, md, bh;
    logic        busy;
    int          n_errors = 0;
    int          checks = 0;
    pcic_if bus ();
    always #5 ref_clk = ~ref_clk;
    pcic_ctrl #(.BASE_PERIOD(BASE_PERIOD)) pcic_ctrl_inst (
        .ref_clk(ref_clk), .rstn(rstn), .bus(bus), .start(start),
        .double_pulse(dbl), .settle_cycles(settle),
        .edge_cycles(edge_len), .mode(mode), .delay(delay), .busy(busy));
    // pixel i sits at row 3*i, column 2: parity equals i
    for (genvar i = 0; i < 2; i++) begin : g
        pcic_pixel pcic_pixel_inst (
            .ref_clk(ref_clk), .rstn(rstn), .bus(bus),
            .row(9'(3 * i)), .col(9'h2), .cfg_write(wr[i]),
            .cfg_enable(en_in[i]), .cal_enable(en[i]),
            .first_inject_switch(fs[i]), .second_inject_switch(ss[i]),
            .inject_upper(up[i]), .inject_middle(md[i]),
            .baseline_hold(bh[i]));
    end
    pcic_props #(.BASE_PERIOD(BASE_PERIOD)) pcic_props_inst (
        .ref_clk(ref_clk), .rstn(rstn), .inject_strobe(bus.inject_strobe),
        .inject_aux(bus.inject_aux), .inject_mode(bus.inject_mode),
        .fine_delay(bus.fine_delay), .baseline_acq(bus.baseline_acq));
    // one mismatch line per failed compare
    task automatic tally(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_sw(input logic [5:0] got, input logic [5:0] exp);
        tally(8'(got), 8'(exp));
    endtask
    task automatic cmp_inj(input logic [3:0] got, input logic [3:0] exp);
        tally(8'(got), 8'(exp));
    endtask
    task automatic cmp_seq(input logic [2:0] got, input logic [2:0] exp);
        tally(8'(got), 8'(exp));
    endtask
    task automatic cmp_base(input logic [2:0] got, input logic [2:0] exp);
        tally(8'(got), 8'(exp));
    endtask
    task automatic results();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // model switch levels from delayed strobe, aux, mode and parity
    function automatic logic [3:0] model_sw();
        logic       e;
        logic [1:0] f;
        logic [1:0] s;
        e = hist[bus.fine_delay];
        for (int i = 0; i < 2; i++) begin
            f[i] = e | bus.inject_aux;
            s[i] = ~e & bus.inject_aux;
            if (bus.inject_mode && ((3 * i + 2) % 2) == 1)
                {f[i], s[i]} = {s[i], f[i]};
        end
        return {f, s};
    endfunction
    // reference model of both pixels, checked every falling edge
    always @(negedge ref_clk) begin
        logic [3:0] m;
        logic       base;
        if (rstn) begin
            for (int i = 0; i < 2; i++) if (wr[i]) den[i] = en_in[i];
            hist = {hist[14:0], bus.inject_strobe};
            m = model_sw();
            base = (cyc % BASE_PERIOD) < BASE_LEN;
            cmp_sw({en, fs, ss}, {den, m});
            cmp_inj({up, md}, {den & m[3:2] & ~pf, den & m[1:0] & ~ps});
            cmp_base({bh, bus.baseline_acq}, {3{base}});
            cyc++;
        end
    end
    // switch history as the pixels register it, mode or delay may move
    always @(posedge ref_clk) begin
        logic [3:0] m;
        m = model_sw();
        pf = rstn ? m[3:2] : 2'h0;
        ps = rstn ? m[1:0] : 2'h0;
    end
    // one prime and inject sequence, with a refused start inside
    task automatic run(input logic m, input logic d, input logic [3:0] dl);
        int         k;
        int         s;
        int         e;
        logic [2:0] exp;
        @(negedge ref_clk);
        mode <= m;
        dbl <= d;
        delay <= dl;
        en_in <= 2'($urandom);
        wr <= 2'h3;
        settle <= 16'($urandom_range(1, 6));
        edge_len <= 16'($urandom_range(1, 5));
        @(negedge ref_clk);
        wr <= 2'h0;
        start <= 1'b1;
        s = int'(settle);
        e = int'(edge_len);
        // busy, strobe and aux per cycle; second start lands in settle
        for (k = 1; k <= s + e + 26; k++) begin
            @(negedge ref_clk);
            if (k == 1 || k == 3) start <= 1'b0;
            if (k == 2) start <= 1'b1;
            exp[2] = (k <= s + e + 5);
            exp[1] = (k >= s + 3) && !(d && k >= s + e + 5);
            exp[0] = (k >= s + e + 4);
            if (k > 1) begin
                cmp_seq({busy, bus.inject_strobe, bus.inject_aux}, exp);
            end else begin
                cmp_seq({busy, 2'h0}, {exp[2], 2'h0});
            end
        end
        $display("test m=%0d d=%0d dl=%0d done", m, d, dl);
    endtask
    // watchdog
    initial begin
        #200000;
        n_errors++;
        results();
    end
    // reset, then every mode and pulse count, delays 0 and 3
    initial begin
        void'($urandom(32'h4aa7c42c));
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        rstn <= 1'b1;
        for (int t = 0; t < 8; t++) run(t[0], t[1], t[2] ? 4'h3 : 4'h0);
        results();
    end
endmodule
`default_nettype wire
